// ===== cfg_stream_pkg.sv
/*
 package for the serial configuration stream source: memory depth,
 mode codes, reset values and the pin drive struct.
 assumes one 25 MHz system clock domain and no software registers.
*/
`default_nettype none
package cfg_stream_pkg;
   // storage depth and address width
   localparam int unsigned MEM_DEPTH  = 256;
   localparam int unsigned ADDR_W     = 8;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_LAST  = 8'hff;
   // oscillator divider: 25 MHz system clock / 8 gives a 320 ns clock
   localparam int unsigned OSC_HALF   = 4;
   localparam logic [2:0]  OSC_HALF_M1 = 3'h3;
   localparam logic [2:0]  OSC_RESET   = 3'h0;

   // loading protocol chosen at output-enable release
   typedef enum logic [1:0] {
      PROTO_A = 2'b00,
      PROTO_B = 2'b01,
      PROTO_C = 2'b10,
      PROTO_D = 2'b11
   } proto_e;

   // stream sequencer states
   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10,
      ST_DONE  = 2'b11
   } stream_state_e;

   // open-drain or tri-state pin as drive level and enable
   typedef struct packed {
      logic o;
      logic oe;
   } pin_drive_s;
endpackage
`default_nettype wire

// ===== cfg_stream_source.sv
/*
 serial configuration stream source: shifts a stored bitstream out
 one bit per serial clock, gated by output-enable and chip-select.
 assumes pins arrive asynchronous to clk; the bench resolves the
 open-drain and tri-state wires from the enables.
*/
// What this block does
// [R01] output-enable and chip-select gate data driver, counter and oscillator
// [R02] output-enable low clears counter to zero and floats data output
// [R03] chip-select high after reset keeps counter stopped and data floating
// [R04] chip-select low with output-enable high enables counter and data driver
// [R05] output-enable low again resets counter regardless of chip-select
// [R06] loading mode is latched when output-enable is released high
// [R07] after last bit and cascade-select low, data output floats
// [R08] output-enable pin only pulls low or releases, never drives high
// [R09] only cascading variants hand over via cascade-select output
// [R10] initiate-configuration instruction drives reconfig request low
// [R11] leaving that state releases reconfig request; target reconfigures
// [R12] target drives chip-select, output-enable and clock directly
// [R13] each rising serial clock advances counter and presents next bit
// [R14] counter advances only when enabled and data not yet all sent
// [R15] first memory makes serial clock from oscillator, others accept it
// [R16] bits leave in ascending address order starting at zero
`timescale 1ns/1ps
`default_nettype none
module cfg_stream_source (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                sys_rst,
   // strap levels
   input  wire logic                cascade_capable,
   input  wire logic                first_in_chain,
   input  wire logic [1:0]          proto_strap,
   // stored bitstream image
   input  wire logic [255:0]        mem_image,
   // target control pins
   input  wire logic                oe_in,
   output logic                     oe_out,
   output logic                     oe_oe,
   input  wire logic                chip_select_n,
   // serial clock pin
   input  wire logic                config_serial_clock_in,
   output logic                     config_serial_clock_out,
   output logic                     config_serial_clock_oe,
   // serial data and cascade
   output logic                     target_serial_data_in,
   output logic                     data_oe,
   output logic                     cascade_select_n,
   // test port state
   input  wire logic                init_conf_state,
   output logic                     reconfig_request_out_n,
   // status
   output cfg_stream_pkg::proto_e   proto_q
);
   // two-flop synchronisers for pin inputs
   logic [1:0] oe_sync_q, cs_sync_q, clk_sync_q, init_sync_q;
   logic       clk_prev_q;
   always_ff @(posedge clk) begin
      oe_sync_q   <= {oe_sync_q[0], oe_in};
      cs_sync_q   <= {cs_sync_q[0], chip_select_n};
      clk_sync_q  <= {clk_sync_q[0], config_serial_clock_in};
      init_sync_q <= {init_sync_q[0], init_conf_state};
      clk_prev_q  <= clk_sync_q[1];
   end

   // straps are pins too; the protocol word is only read at oe release,
   // long after it settles, so two plain flops per bit are enough
   logic [1:0] casc_sync_q, first_sync_q;
   logic [1:0] proto_meta_q, proto_sync_q;
   always_ff @(posedge clk) begin
      casc_sync_q  <= {casc_sync_q[0], cascade_capable};
      first_sync_q <= {first_sync_q[0], first_in_chain};
      proto_meta_q <= proto_strap;
      proto_sync_q <= proto_meta_q;
   end

   logic casc_s, first_s;
   assign casc_s  = casc_sync_q[1];
   assign first_s = first_sync_q[1];

   logic oe_s, cs_n_s, init_s;
   assign oe_s   = oe_sync_q[1];
   assign cs_n_s = cs_sync_q[1];
   assign init_s = init_sync_q[1];

   // sequencer state
   cfg_stream_pkg::stream_state_e st_q, st_d;
   logic [cfg_stream_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic        oe_prev_q;
   logic [2:0]  div_q;
   logic        osc_q;
   logic        sclk_rise;
   logic        enabled;
   logic        last_bit;
   logic        osc_stop;

   // gating: both controls must agree before anything moves
   assign enabled   = oe_s && !cs_n_s;                          // [R01]
   assign last_bit  = (addr_q == cfg_stream_pkg::ADDR_LAST);
   // first memory counts its own oscillator, later ones the pin;
   // advancing the cycle after the oscillator goes high lets the pin
   // rise a full cycle before the data moves, so the target never races
   assign sclk_rise = first_s                                   // [R15]
                    ? (osc_q && div_q == cfg_stream_pkg::OSC_RESET
                       && enabled)
                    : (clk_sync_q[1] && !clk_prev_q);
   // clock parks low when disabled or once the stream is over
   assign osc_stop  = !enabled || (st_q == cfg_stream_pkg::ST_DONE);

   // next state: oe low wins over anything chip-select does
   always_comb begin
      st_d   = st_q;
      addr_d = addr_q;
      if (!oe_s) begin                                          // [R05]
         st_d   = cfg_stream_pkg::ST_RESET;
         addr_d = cfg_stream_pkg::ADDR_RESET;                   // [R02]
      end else begin
         case (st_q)
            cfg_stream_pkg::ST_RESET: st_d = cfg_stream_pkg::ST_IDLE;
            cfg_stream_pkg::ST_IDLE: begin
               if (!cs_n_s)                                     // [R04]
                  st_d = cfg_stream_pkg::ST_SHIFT;              // [R03]
            end
            cfg_stream_pkg::ST_SHIFT: begin
               if (cs_n_s)
                  st_d = cfg_stream_pkg::ST_IDLE;
               else if (sclk_rise) begin                        // [R13]
                  if (last_bit)
                     st_d = cfg_stream_pkg::ST_DONE;            // [R14]
                  else
                     addr_d = addr_q + 8'h01;                   // [R16]
               end
            end
            cfg_stream_pkg::ST_DONE: st_d = cfg_stream_pkg::ST_DONE;
            default: st_d = cfg_stream_pkg::ST_RESET;
         endcase
      end
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q   <= cfg_stream_pkg::ST_RESET;
         addr_q <= cfg_stream_pkg::ADDR_RESET;
      end else begin
         st_q   <= st_d;
         addr_q <= addr_d;
      end
   end

   // internal oscillator runs only while enabled; held low otherwise
   always_ff @(posedge clk) begin
      if (sys_rst || osc_stop) begin                            // [R01]
         div_q <= cfg_stream_pkg::OSC_RESET;
         osc_q <= 1'b0;
      end else if (div_q == cfg_stream_pkg::OSC_HALF_M1) begin
         div_q <= cfg_stream_pkg::OSC_RESET;
         osc_q <= ~osc_q;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   // mode latched on the rising release of output-enable
   always_ff @(posedge clk) begin
      oe_prev_q <= oe_s;
      if (sys_rst)
         proto_q <= cfg_stream_pkg::PROTO_A;
      else if (oe_s && !oe_prev_q)
         proto_q <= cfg_stream_pkg::proto_e'(proto_sync_q);     // [R06]
   end

   // pin outputs, all registered
   logic done;
   assign done = (st_q == cfg_stream_pkg::ST_DONE);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         target_serial_data_in   <= 1'b0;
         data_oe                 <= 1'b0;
         cascade_select_n        <= 1'b1;
         config_serial_clock_out <= 1'b0;
         config_serial_clock_oe  <= 1'b0;
         oe_out                  <= 1'b0;
         oe_oe                   <= 1'b0;
         reconfig_request_out_n  <= 1'b1;
      end else begin
         target_serial_data_in <= mem_image[addr_q];            // [R16]
         // float when not shifting or once the stream is handed on
         data_oe <= (st_q == cfg_stream_pkg::ST_SHIFT) && enabled; // [R07]
         // non-cascading parts never assert the hand-over
         cascade_select_n <= !(done && casc_s && oe_s);         // [R09]
         config_serial_clock_out <= osc_q;
         config_serial_clock_oe  <= first_s;                    // [R15]
         oe_out <= 1'b0;                                        // [R08]
         oe_oe  <= 1'b0;                                        // [R08]
         // follows the test-port state; released as it exits
         reconfig_request_out_n <= !init_s;                     // [R10] [R11]
      end
   end

   // data driver only while both controls enable it
   a_data_gate: assert property (@(posedge clk) disable iff (sys_rst) // [R01]
      data_oe |-> $past(oe_s) && !$past(cs_n_s))
      else $error("data driven while not enabled");
   // oe low: counter cleared next cycle, driver off the cycle after
   sequence s_oe_cleared;
      addr_q == cfg_stream_pkg::ADDR_RESET ##1 !data_oe;
   endsequence
   a_oe_reset: assert property (@(posedge clk) disable iff (sys_rst) // [R02]
      !oe_s |=> s_oe_cleared)
      else $error("oe low did not reset");
   a_cs_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R03]
      (oe_s && cs_n_s && st_q != cfg_stream_pkg::ST_DONE) |=> $stable(addr_q))
      else $error("counter moved with chip select high");
   a_shift_start: assert property (@(posedge clk) disable iff (sys_rst) // [R04]
      (st_q == cfg_stream_pkg::ST_IDLE && oe_s && !cs_n_s) |=>
         st_q == cfg_stream_pkg::ST_SHIFT)
      else $error("shift did not start");
   a_mode_latch: assert property (@(posedge clk) disable iff (sys_rst) // [R06]
      (oe_s && !oe_prev_q) |=> proto_q == $past(proto_sync_q))
      else $error("mode not latched at release");
   a_done_float: assert property (@(posedge clk) disable iff (sys_rst) // [R07]
      done |=> !data_oe)
      else $error("data driven after end of stream");
   a_oe_never_high: assert property (@(posedge clk) // [R08]
      disable iff (sys_rst) !(oe_oe && oe_out))
      else $error("output enable driven high");
   a_no_cascade: assert property (@(posedge clk) disable iff (sys_rst) // [R09]
      !casc_s |=> cascade_select_n)
      else $error("cascade asserted on plain part");
   a_reinit: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
      init_s |=> !reconfig_request_out_n)
      else $error("reconfig request not pulled low");
   a_rq_release: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
      !init_s |=> reconfig_request_out_n)
      else $error("reconfig request not released");
   a_end_hold: assert property (@(posedge clk) disable iff (sys_rst) // [R14]
      (done && oe_s) |=> $stable(addr_q))
      else $error("counter moved after end of stream");
   a_advance: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
      (st_q == cfg_stream_pkg::ST_SHIFT && oe_s && !cs_n_s && sclk_rise
       && !last_bit) |=> addr_q == $past(addr_q) + 8'h01)
      else $error("counter did not advance");
endmodule
`default_nettype wire

// ===== cfg_target_model.sv
/* target logic device model: drives output-enable, chip-select and
 the serial clock, and captures serial data bits on rising clock.
 assumes the bench resolves the shared pin wires. */
`timescale 1ns/1ps
`default_nettype none
module cfg_target_model (
   // commands from bench
   input  wire logic     hold_oe_low,
   input  wire logic     select,
   input  wire logic     drive_clk,
   // resolved pins
   input  wire logic     sclk_pin,
   input  wire logic     data_pin,
   output logic          oe_low,
   output logic          chip_select_n,
   output var logic      sclk_out,
   // captured stream
   output var logic [255:0] bits,
   output var logic [8:0]   nbits
);
   // config pins wired straight, no controller between
   assign oe_low = hold_oe_low;
   assign chip_select_n = ~select;
   // clock runs only inside frames, phase offset from clk
   initial begin
      sclk_out = 1'b0;
      #7;
      forever begin
         #160;
         sclk_out = drive_clk & ~sclk_out;
      end
   end
   // sample before the source moves on; low oe restarts
   always @(posedge sclk_pin or posedge hold_oe_low) begin
      if (hold_oe_low) nbits <= 9'h000;
      else if (select && nbits < 9'h100) begin
         bits[nbits[7:0]] <= data_pin;
         nbits <= nbits + 9'h001;
      end
   end
endmodule
`default_nettype wire

// ===== serial_config_stream_source_test.sv
/* self-checking bench for the stream source with a target model.
 assumes bench-resolved pins: oe pulled up, data floats toggling. */
`timescale 1ns/1ps
`default_nettype none
module serial_config_stream_source_test;
   logic clk = 1'b0, sys_rst = 1'b1, casc = 1'b1, first = 1'b1;
   logic oe_hold = 1'b1, sel = 1'b0, ext = 1'b0, ist = 1'b0, flt = 1'b0;
   logic [1:0] strap = 2'h0;
   logic [255:0] img, bits;
   logic [8:0] nbits;
   logic oe_out, oe_oe, s_out, s_oe, dat, d_oe, casc_n, rq_n, t_oe, cs_n;
   logic t_clk;
   cfg_stream_pkg::proto_e proto;
   int fail_count = 0, checks_done = 0, cyc = 0;
   // wired-and oe with pull-up; floating data toggles
   wire oe_w = ~((oe_oe & ~oe_out) | t_oe);
   wire sclk_w = s_oe ? s_out : t_clk;
   wire dat_w = d_oe ? dat : flt;
   always #20 clk = ~clk;
   always @(negedge clk) flt <= ~flt;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         end_sim();
      end
   end
   cfg_stream_source uut (.clk(clk), .sys_rst(sys_rst),
      .cascade_capable(casc), .first_in_chain(first), .proto_strap(strap),
      .mem_image(img), .oe_in(oe_w), .oe_out(oe_out), .oe_oe(oe_oe),
      .chip_select_n(cs_n), .config_serial_clock_in(sclk_w),
      .config_serial_clock_out(s_out), .config_serial_clock_oe(s_oe),
      .target_serial_data_in(dat), .data_oe(d_oe),
      .cascade_select_n(casc_n), .init_conf_state(ist),
      .reconfig_request_out_n(rq_n), .proto_q(proto));
   cfg_target_model tgt (.hold_oe_low(oe_hold), .select(sel),
      .drive_clk(ext), .sclk_pin(sclk_w), .data_pin(dat_w), .oe_low(t_oe),
      .chip_select_n(cs_n), .sclk_out(t_clk), .bits(bits), .nbits(nbits));
   task automatic check(string n, logic [255:0] s, logic [255:0] e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc_n(int n);
      repeat (n) @(negedge clk);
   endtask
   // bounded wait on the driver enable
   task automatic wait_doe(logic v);
      for (int i = 0; i < 40 && d_oe !== v; i++) @(negedge clk);
   endtask
   task automatic s_cs_high;
      oe_hold = 1'b0;
      cyc_n(20);
      check("data_oe cs high", d_oe, 1'b0);
      check("clock idle", s_out, 1'b0);
      check("oe drive", {oe_oe, oe_out}, 2'h0);
      sel = 1'b1;
      wait_doe(1'b1);
      check("data_oe cs low", d_oe, 1'b1);
      check("first bit", dat, img[0]);
      oe_hold = 1'b1;
      cyc_n(6);
      check("float oe low", d_oe, 1'b0);
      sel = 1'b0;
   endtask
   // whole stream with either clock source
   task automatic s_stream(logic f, logic c, logic [1:0] p);
      first = f;
      casc = c;
      strap = p;
      cyc_n(6);
      sel = 1'b1;
      oe_hold = 1'b0;
      wait_doe(1'b1);
      strap = ~p;
      ext = ~f;
      for (int i = 0; i < 2400 && d_oe === 1'b1; i++) @(negedge clk);
      cyc_n(40);
      check("proto", proto, p);
      check("clock drive", s_oe, f);
      check("clock parked", s_out, 1'b0);
      check("stream", bits, img);
      check("bit count", nbits, 9'h100);
      check("float at end", d_oe, 1'b0);
      check("cascade", casc_n, !c);
      ext = 1'b0;
      oe_hold = 1'b1;
      cyc_n(6);
      check("float oe low", d_oe, 1'b0);
      sel = 1'b0;
   endtask
   task automatic s_reconfig;
      ist = 1'b1;
      cyc_n(5);
      check("request low", rq_n, 1'b0);
      ist = 1'b0;
      cyc_n(5);
      check("request released", rq_n, 1'b1);
   endtask
   task automatic end_sim;
      if (fail_count == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 256; i++) img[i] = ((i * 7 + i / 5) % 3) == 0;
      cyc_n(12);
      sys_rst = 1'b0;
      s_cs_high();
      s_stream(1'b1, 1'b1, 2'h2);
      s_stream(1'b0, 1'b0, 2'h1);
      s_reconfig();
      end_sim();
   end
endmodule
`default_nettype wire
